// [rtl/dcp_pwm.sv]
// Purpose: Dual channel 8-bit pulse width modulator with AXI4-Lite slave
// Assumes: One clock aclk used as the link clock; single outstanding transfers
// Notes:   Channel clocks are enables derived from aclk
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dcp_pwm (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wave_out_ch0,
   output logic             wave_out_ch1
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] awaddr;
      logic        aw_have;
      logic [7:0]  wdata;
      logic        w_lane0;
      logic        w_have;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  ctrl;
      logic [6:0]  presc;
      logic [7:0]  scale_a;
      logic [7:0]  scale_b;
      logic [6:0]  pre_cnt;
      logic [1:0][7:0] cnt;
      logic [1:0]  down;
      logic [1:0][7:0] per_buf;
      logic [1:0][7:0] per_act;
      logic [1:0][7:0] duty_buf;
      logic [1:0][7:0] duty_act;
      logic [1:0]  wave;
      logic [1:0]  run;
   } dcp_state_type;

   dcp_state_type s_q, s_d;
   logic [1:0]  base_tick;
   logic [1:0]  scaled_tick;
   logic [1:0][7:0] scale_in;
   logic [1:0]  ch_tick;
   logic        wr_fire;
   logic [7:0]  wr_idx;
   logic        wr_ok;
   logic [7:0]  rd_idx;
   logic        scl_a_wr;
   logic        scl_b_wr;
   logic        ch_en;
   logic        pol;
   logic        cae;
   logic        cnt_wr;
   logic        per_wr;
   logic        duty_wr;
   logic        at_end;
   logic [7:0]  nxt;

   function automatic logic [7:0] reg_index(input logic [31:0] addr);
      reg_index = addr[9:2];
   endfunction

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx >= dcp_pkg::REG_CTRL) && (idx <= dcp_pkg::REG_DUTY1);
   endfunction

   function automatic logic pre_tick(input logic [6:0] cnt, input logic [2:0] sel);
      logic [6:0] mask;
      mask     = 7'h7f >> (3'h7 - sel);
      pre_tick = (cnt & mask) == mask;
   endfunction

   // ------------------------------------------------------------------
   // Scalers
   // ------------------------------------------------------------------
   assign wr_idx   = reg_index(s_q.awaddr);
   assign wr_fire  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
   assign wr_ok    = wr_fire && mapped(wr_idx) && s_q.w_lane0;
   assign scl_a_wr = wr_ok && (wr_idx == dcp_pkg::REG_SCALEA);
   assign scl_b_wr = wr_ok && (wr_idx == dcp_pkg::REG_SCALEB);
   assign rd_idx   = reg_index(s_axi_araddr);
   assign scale_in = {scl_b_wr ? s_q.wdata : s_q.scale_b,     // see RULE_12
                      scl_a_wr ? s_q.wdata : s_q.scale_a};

   assign base_tick[0] = pre_tick(s_q.pre_cnt, s_q.presc[dcp_pkg::PRESC_A_POS +: 3]); // see RULE_07
   assign base_tick[1] = pre_tick(s_q.pre_cnt, s_q.presc[dcp_pkg::PRESC_B_POS +: 3]); // see RULE_06

   dcp_scaler u_scale_a (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .base_tick   (base_tick[0]),
      .scale_value (scale_in[0]),
      .reload      (scl_a_wr),
      .scaled_tick (scaled_tick[0])
   );

   dcp_scaler u_scale_b (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .base_tick   (base_tick[1]),
      .scale_value (scale_in[1]),
      .reload      (scl_b_wr),
      .scaled_tick (scaled_tick[1])
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d     = s_q;
      ch_tick = '0;
      ch_en   = 1'b0;
      pol     = 1'b0;
      cae     = 1'b0;
      cnt_wr  = 1'b0;
      per_wr  = 1'b0;
      duty_wr = 1'b0;
      at_end  = 1'b0;
      nxt     = 8'h00;
      // Bus slave
      if (s_axi_awvalid && !s_q.aw_have) begin
         s_d.awaddr  = s_axi_awaddr;
         s_d.aw_have = 1'b1;
      end
      if (s_axi_wvalid && !s_q.w_have) begin
         s_d.wdata   = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
         s_d.w_have  = 1'b1;
      end
      if (wr_fire) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = mapped(wr_idx) ? dcp_pkg::RESP_OKAY : dcp_pkg::RESP_SLVERR;
         if (wr_ok) begin
            case (wr_idx)
               dcp_pkg::REG_CTRL:   s_d.ctrl = s_q.wdata;          // see RULE_02, see RULE_03
               dcp_pkg::REG_PRESC:  s_d.presc = {s_q.wdata[6:4], 1'b0, s_q.wdata[2:0]}; // see RULE_08
               dcp_pkg::REG_SCALEA: s_d.scale_a = s_q.wdata;
               dcp_pkg::REG_SCALEB: s_d.scale_b = s_q.wdata;
               default: begin
               end
            endcase
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = mapped(rd_idx) ? dcp_pkg::RESP_OKAY : dcp_pkg::RESP_SLVERR;
         case (rd_idx)
            dcp_pkg::REG_CTRL:   s_d.rdata = {24'h0, s_q.ctrl};
            dcp_pkg::REG_PRESC:  s_d.rdata = {25'h0, s_q.presc};
            dcp_pkg::REG_SCALEA: s_d.rdata = {24'h0, s_q.scale_a};
            dcp_pkg::REG_SCALEB: s_d.rdata = {24'h0, s_q.scale_b};
            dcp_pkg::REG_CNT0:   s_d.rdata = {24'h0, s_q.cnt[0]};      // see RULE_13
            dcp_pkg::REG_CNT1:   s_d.rdata = {24'h0, s_q.cnt[1]};
            dcp_pkg::REG_PER0:   s_d.rdata = {24'h0, s_q.per_buf[0]};  // see RULE_21
            dcp_pkg::REG_PER1:   s_d.rdata = {24'h0, s_q.per_buf[1]};
            dcp_pkg::REG_DUTY0:  s_d.rdata = {24'h0, s_q.duty_buf[0]};
            dcp_pkg::REG_DUTY1:  s_d.rdata = {24'h0, s_q.duty_buf[1]};
            default:             s_d.rdata = 32'h0;
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // Prescaler runs only while a channel is enabled
      if (s_q.ctrl[dcp_pkg::CTRL_EN_POS +: 2] != 2'b00) begin
         s_d.pre_cnt = s_q.pre_cnt + 7'h01;
      end else begin
         s_d.pre_cnt = 7'h00;
      end
      // Channels
      for (int i = 0; i < 2; i++) begin
         ch_en   = s_q.ctrl[dcp_pkg::CTRL_EN_POS + i];
         pol     = s_q.ctrl[dcp_pkg::CTRL_POL_POS + i];
         cae     = s_q.ctrl[dcp_pkg::CTRL_CAE_POS + i];
         ch_tick[i] = s_q.ctrl[dcp_pkg::CTRL_CLK_POS + i] ? scaled_tick[i] : base_tick[i]; // see RULE_23
         cnt_wr  = wr_ok && (wr_idx == dcp_pkg::REG_CNT0 + 8'(i));
         per_wr  = wr_ok && (wr_idx == dcp_pkg::REG_PER0 + 8'(i));
         duty_wr = wr_ok && (wr_idx == dcp_pkg::REG_DUTY0 + 8'(i));
         if (per_wr) begin
            s_d.per_buf[i] = s_q.wdata;
            if (!ch_en) begin
               s_d.per_act[i] = s_q.wdata;                 // see RULE_20
            end
         end
         if (duty_wr) begin
            s_d.duty_buf[i] = s_q.wdata;
            if (!ch_en) begin
               s_d.duty_act[i] = s_q.wdata;
            end
         end
         if (!ch_en) begin
            s_d.run[i]      = 1'b0;
            s_d.per_act[i]  = s_d.per_buf[i];              // see RULE_19
            s_d.duty_act[i] = s_d.duty_buf[i];
         end else if (ch_tick[i]) begin
            s_d.run[i] = 1'b1;                             // see RULE_24
         end
         if (cnt_wr) begin
            s_d.cnt[i]      = 8'h00;                       // see RULE_16
            s_d.down[i]     = 1'b0;
            s_d.per_act[i]  = s_d.per_buf[i];
            s_d.duty_act[i] = s_d.duty_buf[i];
            s_d.wave[i]     = pol;
         end else if (ch_en && ch_tick[i]) begin           // see RULE_18
            if (!cae) begin                                // see RULE_04
               nxt    = s_q.cnt[i] + 8'h01;
               at_end = (nxt >= s_q.per_act[i]);           // see RULE_14
            end else if (!s_q.down[i]) begin
               nxt    = s_q.cnt[i] + 8'h01;
               at_end = 1'b0;
               if (nxt >= s_q.per_act[i]) begin            // see RULE_15
                  s_d.down[i] = 1'b1;
               end
            end else begin
               nxt    = s_q.cnt[i] - 8'h01;
               at_end = (s_q.cnt[i] <= 8'h01);
            end
            if (at_end) begin
               s_d.cnt[i]      = 8'h00;                    // see RULE_17
               s_d.down[i]     = 1'b0;
               s_d.per_act[i]  = s_q.per_buf[i];           // see RULE_19
               s_d.duty_act[i] = s_q.duty_buf[i];
               s_d.wave[i]     = pol;                      // see RULE_01
            end else begin
               s_d.cnt[i] = nxt;                           // see RULE_22
               if (nxt == s_q.duty_act[i]) begin
                  s_d.wave[i] = ~pol;                      // see RULE_01
               end else if (nxt < s_q.duty_act[i]) begin
                  s_d.wave[i] = pol;                       // see RULE_02
               end
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign s_axi_awready = !s_q.aw_have;
   assign s_axi_wready  = !s_q.w_have;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign wave_out_ch0  = s_q.run[0] ? s_q.wave[0] : s_q.ctrl[dcp_pkg::CTRL_POL_POS];
   assign wave_out_ch1  = s_q.run[1] ? s_q.wave[1] : s_q.ctrl[dcp_pkg::CTRL_POL_POS + 1];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_cnt_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_18
      !s_q.ctrl[0] && !wr_ok |=> $stable(s_q.cnt[0]))
      else $error("disabled counter moved");
   a_cnt_stay: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_18
      !s_q.ctrl[1] && !wr_ok |=> $stable(s_q.cnt[1]))
      else $error("disabled counter one moved");
   a_left_bound: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_14
      !s_q.ctrl[6] && s_q.per_act[0] != 8'h00 && !s_q.down[0] |-> s_q.cnt[0] < s_q.per_act[0]
      || $past(s_q.ctrl[6]) || $past(s_q.per_act[0]) != s_q.per_act[0])
      else $error("left count out of range");
   a_left_step: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_14
      s_q.ctrl[0] && !s_q.ctrl[6] && ch_tick[0] && !wr_ok && s_q.cnt[0] + 8'h01 < s_q.per_act[0]
      |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 8'h01)
      else $error("left count did not step");
   a_left_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_17
      s_q.ctrl[0] && !s_q.ctrl[6] && ch_tick[0] && !wr_ok && s_q.cnt[0] + 8'h01 >= s_q.per_act[0]
      |=> s_q.cnt[0] == 8'h00 && s_q.wave[0] == s_q.ctrl[2])
      else $error("left period did not wrap");
   a_wave_match: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_01
      s_q.ctrl[0] && !s_q.ctrl[6] && ch_tick[0] && !wr_ok && s_q.cnt[0] + 8'h01 < s_q.per_act[0]
      && s_q.cnt[0] + 8'h01 == s_q.duty_act[0] |=> s_q.wave[0] != s_q.ctrl[2])
      else $error("duty match did not flip");
   a_center_top: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_15
      s_q.ctrl[1] && s_q.ctrl[7] && ch_tick[1] && !wr_ok && !s_q.down[1]
      && s_q.cnt[1] + 8'h01 >= s_q.per_act[1] |=> s_q.down[1])
      else $error("center count did not turn");
   a_center_end: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_17
      s_q.ctrl[1] && s_q.ctrl[7] && ch_tick[1] && !wr_ok && s_q.down[1] && s_q.cnt[1] <= 8'h01
      |=> s_q.cnt[1] == 8'h00 && !s_q.down[1])
      else $error("center period did not end");
   a_cnt_write: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_16
      wr_ok && wr_idx == dcp_pkg::REG_CNT0 |=> s_q.cnt[0] == 8'h00 && !s_q.down[0]
      && s_q.wave[0] == s_q.ctrl[2] && s_q.per_act[0] == s_q.per_buf[0])
      else $error("counter write failed");
   a_per_buffered: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_19
      wr_ok && wr_idx == dcp_pkg::REG_PER0 && s_q.ctrl[0] && !s_q.ctrl[6]
      && s_q.cnt[0] + 8'h01 < s_q.per_act[0] |=> $stable(s_q.per_act[0]))
      else $error("period not buffered");
   a_per_direct: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_20
      wr_ok && wr_idx == dcp_pkg::REG_PER1 && !s_q.ctrl[1] |=> s_q.per_act[1] == $past(s_q.wdata))
      else $error("period not direct");
   a_per_read: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_21
      s_axi_arvalid && !s_q.rvalid && rd_idx == dcp_pkg::REG_PER0
      |=> s_q.rdata[7:0] == $past(s_q.per_buf[0])) else $error("period read wrong");
   a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
      wr_ok && wr_idx == dcp_pkg::REG_CTRL |=> s_q.ctrl == $past(s_q.wdata))
      else $error("control write lost");
   a_presc_write: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_08
      wr_ok && wr_idx == dcp_pkg::REG_PRESC
      |=> s_q.presc == {$past(s_q.wdata[6:4]), 1'b0, $past(s_q.wdata[2:0])})
      else $error("prescale write lost");
   a_pre_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
      s_q.presc[2:0] == 3'h1 && base_tick[0] |=> !base_tick[0])
      else $error("prescale A rate wrong");
   a_pre_b: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_06
      s_q.presc[6:4] == 3'h0 && s_q.ctrl[1:0] != 2'b00 |-> base_tick[1])
      else $error("prescale B rate wrong");
   a_clk_sel: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_23
      s_q.ctrl[4] |-> ch_tick[0] == scaled_tick[0])
      else $error("clock select wrong");
   a_clk_sel1: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_23
      !s_q.ctrl[5] |-> ch_tick[1] == base_tick[1])
      else $error("clock select one wrong");
   a_run_start: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_24
      $rose(s_q.run[1]) |-> $past(ch_tick[1]) && $past(s_q.ctrl[1]))
      else $error("wave started early");
   a_run_start0: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_24
      $rose(s_q.run[0]) |-> $past(ch_tick[0]) && $past(s_q.ctrl[0]))
      else $error("wave zero started early");
endmodule // dcp_pwm

// [rtl/dcp_pkg.sv]
// Purpose: Constants for the dual channel 8-bit pulse width modulator
// Assumes: AXI4-Lite register access, one word per register
// Notes:   Register index times four is the byte address
//
// What this block does
// RULE_01 - Polarity one starts high, zero starts low
// RULE_02 - Polarity bits writable at any time
// RULE_03 - Clock select bits writable at any time
// RULE_04 - Center align bit selects center aligned wave
// RULE_05 - Software changes alignment only while disabled
// RULE_06 - Clock B is link clock over two-power
// RULE_07 - Clock A is link clock over two-power
// RULE_08 - Prescale select fields writable at any time
// RULE_09 - Clock SA is clock A over scale, halved
// RULE_10 - Scale A zero means 256
// RULE_11 - Clock SB likewise from clock B, zero 256
// RULE_12 - Scale write reloads that scaler down counter
// RULE_13 - Own 8-bit counter per channel, reads harmless
// RULE_14 - Left aligned counts zero to period minus one
// RULE_15 - Center aligned counts up to period, down
// RULE_16 - Counter write resets count, direction, loads, output
// RULE_17 - Counter clears at end of effective period
// RULE_18 - Disabled counter holds; enabling resumes from it
// RULE_19 - Enabled period write buffered until period boundary
// RULE_20 - Disabled period write updates buffer and active
// RULE_21 - Period read returns buffered value
// RULE_22 - Period is clock times period, doubled centered
// RULE_23 - Clock select zero base clock, one scaled
// RULE_24 - Waveform starts at next selected clock cycle
package dcp_pkg;
   localparam logic [7:0] REG_CTRL   = 8'h60;
   localparam logic [7:0] REG_PRESC  = 8'h61;
   localparam logic [7:0] REG_SCALEA = 8'h62;
   localparam logic [7:0] REG_SCALEB = 8'h63;
   localparam logic [7:0] REG_CNT0   = 8'h64;
   localparam logic [7:0] REG_CNT1   = 8'h65;
   localparam logic [7:0] REG_PER0   = 8'h66;
   localparam logic [7:0] REG_PER1   = 8'h67;
   localparam logic [7:0] REG_DUTY0  = 8'h68;
   localparam logic [7:0] REG_DUTY1  = 8'h69;
   localparam int ADDR_SHIFT   = 2;
   localparam int CTRL_EN_POS  = 0;
   localparam int CTRL_POL_POS = 2;
   localparam int CTRL_CLK_POS = 4;
   localparam int CTRL_CAE_POS = 6;
   localparam int PRESC_A_POS  = 0;
   localparam int PRESC_B_POS  = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [6:0] PRESC_RESET = 7'h00;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [rtl/dcp_scaler.sv]
// Purpose: Scaled clock enable from a base clock enable
// Assumes: Base enable is a one-cycle pulse per base clock cycle
// Notes:   Output pulse rate is base over twice the scale value
`timescale 1ns/10ps
module dcp_scaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       base_tick,
   input  wire logic [7:0] scale_value,
   input  wire logic       reload,
   output logic            scaled_tick
);
   typedef struct packed {
      logic [7:0] down;
      logic       half;
   } dcp_scl_type;
   dcp_scl_type s_q, s_d;
   logic        hit;

   always_comb begin
      s_d = s_q;
      hit = 1'b0;
      if (reload) begin
         s_d.down = scale_value;                             // see RULE_12
      end else if (base_tick) begin
         if (s_q.down == 8'h01) begin
            s_d.down = scale_value;                          // see RULE_10
            hit      = 1'b1;
            s_d.half = ~s_q.half;                            // see RULE_09
         end else begin
            s_d.down = s_q.down - 8'h01;                     // see RULE_10
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign scaled_tick = hit & s_q.half;                      // see RULE_11

   a_reload_scale: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_12
      reload |=> s_q.down == $past(scale_value)) else $error("scaler not reloaded");
endmodule // dcp_scaler

// [sim/dcp_driver_model.sv]
// Purpose: Output driver model that times the waveform it receives
// Assumes: One waveform input sampled on aclk
// Notes:   Gap and high time are counted in aclk cycles
`timescale 1ns/10ps
module dcp_driver_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        wave,
   output logic [15:0]      rise_gap,
   output logic [15:0]      high_len
);
   logic [15:0] since_rise;
   logic        wave_q;
   // ---------------------------------------
   // Edge timing
   // ---------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_q     <= 1'b0;
         since_rise <= 16'h0000;
         rise_gap   <= 16'h0000;
         high_len   <= 16'h0000;
      end else begin
         wave_q     <= wave;
         since_rise <= since_rise + 16'h0001;
         if (wave && !wave_q) begin
            rise_gap   <= since_rise + 16'h0001;
            since_rise <= 16'h0000;
         end
         if (!wave && wave_q) begin
            high_len <= since_rise + 16'h0001;
         end
      end
   end
endmodule // dcp_driver_model

// [sim/testbench.sv]
// Purpose: Register and waveform tests of the pulse width modulator
// Assumes: AXI4-Lite master tasks, byte address is index times four
// Notes:   Waveform timing measured by two driver models
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module testbench;
   logic        aclk, aresetn;
   logic [31:0] awaddr, wdata, araddr, rdata, rd_data;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, wave0, wave1;
   logic [1:0]  bresp, rresp, wr_resp, rd_resp;
   logic [15:0] gap0, gap1, high0, high1;
   logic [31:0] cnt_a;
   int          n_mismatch, checks_done, i;
   dcp_pwm dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .wave_out_ch0(wave0), .wave_out_ch1(wave1));
   dcp_driver_model drv0 (.aclk(aclk), .aresetn(aresetn), .wave(wave0),
      .rise_gap(gap0), .high_len(high0));
   dcp_driver_model drv1 (.aclk(aclk), .aresetn(aresetn), .wave(wave1),
      .rise_gap(gap1), .high_len(high1));
   // ---------------------------------------
   // Bus tasks
   // ---------------------------------------
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr  <= {22'h0, idx, 2'b00};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      wr_resp = bresp;
      bready <= 1'b0;
      if (n == 100) n_mismatch++;
   endtask
   task automatic axi_rd(input logic [7:0] idx);
      int n;
      @(posedge aclk);
      araddr  <= {22'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      if (n == 100) n_mismatch++;
   endtask
   task give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ---------------------------------------
   // Clock, reset, watchdog
   // ---------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      give_verdict;
   end
   // ---------------------------------------
   // Tests
   // ---------------------------------------
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = 32'h0;
      wdata   = 32'h0;
      araddr  = 32'h0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 4; i++) begin
         axi_rd(dcp_pkg::REG_SCALEA + 8'(i));
         `CHK("reset value", 32'h0, rd_data)
      end
      axi_rd(8'h70);
      `CHK("unmapped rresp", dcp_pkg::RESP_SLVERR, rd_resp)
      axi_wr(8'h70, 8'h5a);
      `CHK("unmapped bresp", dcp_pkg::RESP_SLVERR, wr_resp)
      axi_wr(dcp_pkg::REG_CTRL, 8'h0c);
      repeat (3) @(posedge aclk);
      `CHK("idle level high", 2'b11, {wave1, wave0})
      axi_wr(dcp_pkg::REG_CTRL, 8'h00);
      repeat (3) @(posedge aclk);
      `CHK("idle level low", 2'b00, {wave1, wave0})
      axi_wr(dcp_pkg::REG_PER0, 8'h04);
      axi_wr(dcp_pkg::REG_PER1, 8'h04);
      axi_wr(dcp_pkg::REG_DUTY0, 8'h02);
      axi_wr(dcp_pkg::REG_DUTY1, 8'h02);
      axi_rd(dcp_pkg::REG_PER0);
      `CHK("period readback", 32'h4, rd_data)
      axi_wr(dcp_pkg::REG_CTRL, 8'h0f);
      // Every prescale code, changed under a running waveform
      for (i = 0; i < 8; i++) begin
         axi_wr(dcp_pkg::REG_PRESC, 8'(i * 17));
         repeat (3 * (4 << i) + 20) @(posedge aclk);
         `CHK("gap clock A", 16'(4 << i), gap0)
         `CHK("gap clock B", 16'(4 << i), gap1)
         `CHK("high time", 16'(2 << i), high0)
      end
      axi_wr(dcp_pkg::REG_PRESC, 8'h00);
      axi_wr(dcp_pkg::REG_PER0, 8'h06);
      axi_rd(dcp_pkg::REG_PER0);
      `CHK("buffered period", 32'h6, rd_data)
      repeat (40) @(posedge aclk);
      `CHK("left period", 16'h6, gap0)
      axi_wr(dcp_pkg::REG_SCALEA, 8'h03);
      axi_wr(dcp_pkg::REG_SCALEB, 8'h00);
      axi_wr(dcp_pkg::REG_CTRL, 8'h3f);
      repeat (6600) @(posedge aclk);
      `CHK("gap clock SA", 16'd36, gap0)
      `CHK("gap clock SB", 16'd2048, gap1)
      axi_wr(dcp_pkg::REG_CTRL, 8'h0c);
      axi_rd(dcp_pkg::REG_CNT0);
      cnt_a = rd_data;
      repeat (20) @(posedge aclk);
      axi_rd(dcp_pkg::REG_CNT0);
      `CHK("held count", cnt_a, rd_data)
      axi_wr(dcp_pkg::REG_CNT0, 8'h33);
      axi_rd(dcp_pkg::REG_CNT0);
      `CHK("cleared count", 32'h0, rd_data)
      `CHK("disabled level", 1'b1, wave0)
      // Alignment changed only with both channels off
      axi_wr(dcp_pkg::REG_CTRL, 8'h88);
      axi_wr(dcp_pkg::REG_CTRL, 8'h8a);
      repeat (60) @(posedge aclk);
      `CHK("center period", 16'h8, gap1)
      `CHK("other idle", 1'b0, wave0)
      give_verdict;
   end
endmodule // testbench
